/* File: rpt_params.svh */
`ifndef RPT_PARAMS_SVH
`define RPT_PARAMS_SVH

`define RPT_ADDR_W 20
`define RPT_IDX_W 18
`define RPT_IDX_X 18'h0DF12
`define RPT_IDX_Y 18'h0DF13
`define RPT_IDX_Z 18'h0DF14
`define RPT_IDX_CTRL 18'h0DF15
`define RPT_IDX_PWR 18'h0DF17
`define RPT_IDX_TCH 18'h0DF20
`define RPT_IDX_TCL 18'h0DF21
`define RPT_IDX_MASK 18'h0DF22

`define RPT_RST_ZERO 8'h00
`define RPT_RST_PWR_CTL 1'b1
`define RPT_RST_PWR_DLY 3'b100
`define RPT_RST_TCH 8'h7A
`define RPT_RST_TCL 8'h94
`define RPT_RST_MASK 8'hFF

`define RPT_CTRL_CPU 0
`define RPT_PWR_DLY 2:0
`define RPT_PWR_CTL 3
`define RPT_PWR_STAT 4
`define RPT_TCH_RX2RX 7:5
`define RPT_TCH_SW2TX 4:2
`define RPT_TCH_PAHI 1:0
`define RPT_TCL_PALO 7:6
`define RPT_TCL_END2SW 5:3
`define RPT_TCL_END2PA 2:0
`define RPT_M_VGA_RST 7
`define RPT_M_BIAS 6
`define RPT_M_SW_BIAS 5
`define RPT_M_BUF_SEL 4
`define RPT_M_PRE 3
`define RPT_M_AMP_N 2
`define RPT_M_AMP_P 1
`define RPT_M_DAC 0

`define RPT_CLK_MHZ 25
`define RPT_RX2RX_STEP_US 5
`define RPT_CAL_HALF_SYMS 13
`define RPT_SYMBOL_US 16
`define RPT_DLY_US0 0
`define RPT_DLY_US1 31
`define RPT_DLY_US2 63
`define RPT_DLY_US3 125
`define RPT_DLY_US4 250
`define RPT_DLY_US5 500
`define RPT_DLY_US6 1000
`define RPT_DLY_US7 2000

`define RPT_RESP_OKAY 2'b00
`define RPT_RESP_SLVERR 2'b10

`endif

/* File: rpt_pkg.sv */
package rpt_pkg;
    typedef enum logic [2:0] {
        RPT_IDLE = 3'b000,
        RPT_RX_CAL = 3'b001,
        RPT_RX_CHAIN = 3'b010,
        RPT_RX_ON = 3'b011,
        RPT_TX_LEAD = 3'b100,
        RPT_TX_ON = 3'b101,
        RPT_TX_TAIL = 3'b110
    } rpt_state_t;
endpackage : rpt_pkg

/* File: rpt_regs.sv */
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "rpt_params.svh"
module rpt_regs #(
    parameter int unsigned DLY_CYC [8] = '{
        `RPT_DLY_US0 * `RPT_CLK_MHZ, `RPT_DLY_US1 * `RPT_CLK_MHZ,
        `RPT_DLY_US2 * `RPT_CLK_MHZ, `RPT_DLY_US3 * `RPT_CLK_MHZ,
        `RPT_DLY_US4 * `RPT_CLK_MHZ, `RPT_DLY_US5 * `RPT_CLK_MHZ,
        `RPT_DLY_US6 * `RPT_CLK_MHZ, `RPT_DLY_US7 * `RPT_CLK_MHZ}
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [`RPT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`RPT_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_enable_req,
    input wire logic tx_start,
    input wire logic tx_last_chip,
    output logic [7:0] seq_operand_x,
    output logic [7:0] seq_operand_y,
    output logic [7:0] seq_operand_z,
    output logic seq_cpu_ctrl,
    output logic regulator_powerdown_ctl,
    output logic delayed_analog_powerdown,
    output logic rx_chain_en,
    output logic demod_en,
    output logic tx_en,
    output logic mod_en,
    output logic pa_on,
    output logic vga_reset_n,
    output logic global_bias_off,
    output logic output_switch_bias_ctl,
    output logic buffer_select,
    output logic prescaler_off,
    output logic amp_neg_path_off,
    output logic amp_pos_path_off,
    output logic tx_converter_off,
    output logic up_mixer_off
);
    // Cycle counts derived from the microsecond figures
    localparam int unsigned CAL_CYC =
        (`RPT_CAL_HALF_SYMS * `RPT_SYMBOL_US * `RPT_CLK_MHZ + 1) / 2;
    localparam logic [15:0] MHZ = 16'(`RPT_CLK_MHZ);
    localparam logic [15:0] RX_STEP = 16'(`RPT_RX2RX_STEP_US * `RPT_CLK_MHZ);

    logic [2:0] dly_sel;
    logic [7:0] timing_high, timing_low, mask, w_byte, rd_val;
    logic [15:0] pd_cnt, st_cnt, lead_cyc, sw_on_at, pa_on_at, sw_off_at, pa_off_at;
    logic aw_held, w_held, w_lane0, do_write, wr_hit, rd_hit;
    logic [`RPT_IDX_W-1:0] aw_idx, rd_idx;
    rpt_pkg::rpt_state_t state, next_state;
    logic [3:0] amp_lead;
    logic g_rx_chain, g_demod, g_tx, g_switch, g_pa, g_tx_side;

    assign amp_lead = {timing_high[`RPT_TCH_PAHI], timing_low[`RPT_TCL_PALO]};
    assign lead_cyc = (amp_lead > {1'b0, timing_high[`RPT_TCH_SW2TX]})
        ? 16'(amp_lead) * MHZ : 16'(timing_high[`RPT_TCH_SW2TX]) * MHZ;
    assign sw_on_at = lead_cyc - 16'(timing_high[`RPT_TCH_SW2TX]) * MHZ;
    assign pa_on_at = lead_cyc - 16'(amp_lead) * MHZ;
    assign sw_off_at = 16'(timing_low[`RPT_TCL_END2SW]) * MHZ;
    assign pa_off_at = 16'(timing_low[`RPT_TCL_END2PA]) * MHZ;
    assign do_write = (aw_held || (s_axi_awvalid && s_axi_awready))
        && (w_held || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
    assign rd_idx = s_axi_araddr[`RPT_ADDR_W-1:2];

    // Write channel capture; address and data may arrive in either order
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= '0;
            w_byte <= `RPT_RST_ZERO;
            w_lane0 <= 1'b0;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_idx <= s_axi_awaddr[`RPT_ADDR_W-1:2];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
        end
    end

    // Ready flags; one write outstanding, so each drops once its own half is held
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !(aw_held || (s_axi_awvalid && s_axi_awready)) && !do_write && !s_axi_bvalid;
            s_axi_wready <= !(w_held || (s_axi_wvalid && s_axi_wready)) && !do_write && !s_axi_bvalid;
        end
    end

    // Combined write address, data and strobe in one view
    logic [`RPT_IDX_W-1:0] wr_idx;
    logic [7:0] wr_byte;
    logic wr_en;
    assign wr_idx = aw_held ? aw_idx : s_axi_awaddr[`RPT_ADDR_W-1:2];
    assign wr_byte = w_held ? w_byte : s_axi_wdata[7:0];
    assign wr_en = do_write && (w_held ? w_lane0 : s_axi_wstrb[0]);

    // Write decode, used only for the response code
    always_comb
    begin
        if (wr_idx == `RPT_IDX_X) wr_hit = 1'b1;
        else if (wr_idx == `RPT_IDX_Y) wr_hit = 1'b1;
        else if (wr_idx == `RPT_IDX_Z) wr_hit = 1'b1;
        else if (wr_idx == `RPT_IDX_CTRL) wr_hit = 1'b1;
        else if (wr_idx == `RPT_IDX_PWR) wr_hit = 1'b1;
        else if (wr_idx == `RPT_IDX_TCH) wr_hit = 1'b1;
        else if (wr_idx == `RPT_IDX_TCL) wr_hit = 1'b1;
        else if (wr_idx == `RPT_IDX_MASK) wr_hit = 1'b1;
        else wr_hit = 1'b0;
    end

    // Write response, unmapped addresses answer SLVERR
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RPT_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RPT_RESP_OKAY : `RPT_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Sequencer operands and control bit
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            seq_operand_x <= `RPT_RST_ZERO;
            seq_operand_y <= `RPT_RST_ZERO;
            seq_operand_z <= `RPT_RST_ZERO;
            seq_cpu_ctrl <= 1'b0;
        end
        else if (wr_en)
        begin
            if (wr_idx == `RPT_IDX_X) seq_operand_x <= wr_byte;
            else if (wr_idx == `RPT_IDX_Y) seq_operand_y <= wr_byte;
            else if (wr_idx == `RPT_IDX_Z) seq_operand_z <= wr_byte;
            else if (wr_idx == `RPT_IDX_CTRL) seq_cpu_ctrl <= wr_byte[`RPT_CTRL_CPU];
        end
    end

    // Power, timing and mask registers
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            regulator_powerdown_ctl <= `RPT_RST_PWR_CTL;
            dly_sel <= `RPT_RST_PWR_DLY;
            timing_high <= `RPT_RST_TCH;
            timing_low <= `RPT_RST_TCL;
            mask <= `RPT_RST_MASK;
        end
        else if (wr_en)
        begin
            if (wr_idx == `RPT_IDX_PWR)
            begin
                regulator_powerdown_ctl <= wr_byte[`RPT_PWR_CTL];
                dly_sel <= wr_byte[`RPT_PWR_DLY];
            end
            else if (wr_idx == `RPT_IDX_TCH) timing_high <= wr_byte;
            else if (wr_idx == `RPT_IDX_TCL) timing_low <= wr_byte;
            else if (wr_idx == `RPT_IDX_MASK) mask <= wr_byte;
        end
    end

    // Delayed status; power-up waits, power-down drops at once so analog never outlives the supply
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            delayed_analog_powerdown <= 1'b0;
            pd_cnt <= '0;
        end
        else if (regulator_powerdown_ctl)
        begin
            delayed_analog_powerdown <= 1'b0;
            pd_cnt <= '0;
        end
        else if (!delayed_analog_powerdown)
        begin
            if (pd_cnt >= 16'(DLY_CYC[dly_sel]))
                delayed_analog_powerdown <= 1'b1;
            else
                pd_cnt <= pd_cnt + 16'h0001;
        end
    end

    // Read data mux
    always_comb
    begin
        rd_hit = 1'b1;
        if (rd_idx == `RPT_IDX_X) rd_val = seq_operand_x;
        else if (rd_idx == `RPT_IDX_Y) rd_val = seq_operand_y;
        else if (rd_idx == `RPT_IDX_Z) rd_val = seq_operand_z;
        else if (rd_idx == `RPT_IDX_CTRL) rd_val = {7'h00, seq_cpu_ctrl};
        else if (rd_idx == `RPT_IDX_PWR)
            rd_val = {3'h0, delayed_analog_powerdown, regulator_powerdown_ctl, dly_sel};
        else if (rd_idx == `RPT_IDX_TCH) rd_val = timing_high;
        else if (rd_idx == `RPT_IDX_TCL) rd_val = timing_low;
        else if (rd_idx == `RPT_IDX_MASK)
            rd_val = {mask[7], 1'b0, mask[5:0]};
        else
        begin
            rd_val = `RPT_RST_ZERO;
            rd_hit = 1'b0;
        end
    end

    // Read channel; data sampled when the address is taken
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `RPT_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_hit ? `RPT_RESP_OKAY : `RPT_RESP_SLVERR;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
        begin
            s_axi_arready <= 1'b1;
        end
    end

    // Radio controller sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            rpt_pkg::RPT_IDLE:
                if (tx_start) next_state = rpt_pkg::RPT_TX_LEAD;
                else if (rx_enable_req) next_state = rpt_pkg::RPT_RX_CAL;
            rpt_pkg::RPT_RX_CAL:
                if (!rx_enable_req) next_state = rpt_pkg::RPT_IDLE;
                else if (st_cnt >= 16'(CAL_CYC)) next_state = rpt_pkg::RPT_RX_CHAIN;
            rpt_pkg::RPT_RX_CHAIN:
                if (!rx_enable_req) next_state = rpt_pkg::RPT_IDLE;
                else if (st_cnt >= 16'(timing_high[`RPT_TCH_RX2RX]) * RX_STEP)
                    next_state = rpt_pkg::RPT_RX_ON;
            rpt_pkg::RPT_RX_ON:
                if (tx_start) next_state = rpt_pkg::RPT_TX_LEAD;
                else if (!rx_enable_req) next_state = rpt_pkg::RPT_IDLE;
            rpt_pkg::RPT_TX_LEAD:
                if (st_cnt >= lead_cyc) next_state = rpt_pkg::RPT_TX_ON;
            rpt_pkg::RPT_TX_ON:
                if (tx_last_chip) next_state = rpt_pkg::RPT_TX_TAIL;
            rpt_pkg::RPT_TX_TAIL:
                if (st_cnt >= sw_off_at && st_cnt >= pa_off_at) next_state = rpt_pkg::RPT_IDLE;
            default:
                next_state = rpt_pkg::RPT_IDLE;
        endcase
    end

    // State register and time-in-state counter; analog off forces idle
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state <= rpt_pkg::RPT_IDLE;
            st_cnt <= '0;
        end
        else if (!delayed_analog_powerdown)
        begin
            state <= rpt_pkg::RPT_IDLE;
            st_cnt <= '0;
        end
        else if (next_state != state)
        begin
            state <= next_state;
            st_cnt <= '0;
        end
        else if (st_cnt != 16'hFFFF)
        begin
            st_cnt <= st_cnt + 16'h0001;
        end
    end

    // Controller-generated controls before masking
    always_comb
    begin
        g_rx_chain = (state == rpt_pkg::RPT_RX_CHAIN) || (state == rpt_pkg::RPT_RX_ON);
        g_demod = (state == rpt_pkg::RPT_RX_ON);
        g_tx = (state == rpt_pkg::RPT_TX_ON);
        g_tx_side = (state == rpt_pkg::RPT_TX_LEAD) || g_tx || (state == rpt_pkg::RPT_TX_TAIL);
        g_switch = g_tx || ((state == rpt_pkg::RPT_TX_LEAD) && st_cnt >= sw_on_at)
            || ((state == rpt_pkg::RPT_TX_TAIL) && st_cnt < sw_off_at);
        g_pa = g_tx || ((state == rpt_pkg::RPT_TX_LEAD) && st_cnt >= pa_on_at)
            || ((state == rpt_pkg::RPT_TX_TAIL) && st_cnt < pa_off_at);
    end

    // Registered outputs; mask ANDs each bias, buffer, amp, mixer and converter control, then analog-off forces power-down on all but buffer_select
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            rx_chain_en <= 1'b0;
            demod_en <= 1'b0;
            tx_en <= 1'b0;
            mod_en <= 1'b0;
            pa_on <= 1'b0;
            vga_reset_n <= 1'b0;
            global_bias_off <= 1'b1;
            output_switch_bias_ctl <= 1'b0;
            buffer_select <= 1'b0;
            prescaler_off <= 1'b1;
            amp_neg_path_off <= 1'b1;
            amp_pos_path_off <= 1'b1;
            tx_converter_off <= 1'b1;
            up_mixer_off <= 1'b1;
        end
        else
        begin
            rx_chain_en <= delayed_analog_powerdown && g_rx_chain;
            demod_en <= delayed_analog_powerdown && g_demod;
            tx_en <= delayed_analog_powerdown && g_tx;
            mod_en <= delayed_analog_powerdown && g_pa;
            pa_on <= delayed_analog_powerdown && g_pa;
            vga_reset_n <= mask[`RPT_M_VGA_RST] && g_demod && delayed_analog_powerdown;
            global_bias_off <= (mask[`RPT_M_BIAS] && (state == rpt_pkg::RPT_IDLE))
                || !delayed_analog_powerdown;
            output_switch_bias_ctl <= mask[`RPT_M_SW_BIAS] && g_switch
                && delayed_analog_powerdown;
            buffer_select <= mask[`RPT_M_BUF_SEL] && g_tx_side;
            prescaler_off <= (mask[`RPT_M_PRE] && (state == rpt_pkg::RPT_IDLE))
                || !delayed_analog_powerdown;
            amp_neg_path_off <= (mask[`RPT_M_AMP_N] && !g_pa) || !delayed_analog_powerdown;
            amp_pos_path_off <= (mask[`RPT_M_AMP_P] && !g_pa) || !delayed_analog_powerdown;
            tx_converter_off <= (mask[`RPT_M_DAC] && !g_pa) || !delayed_analog_powerdown;
            up_mixer_off <= (mask[`RPT_M_AMP_N] && mask[`RPT_M_AMP_P] && !g_pa)
                || !delayed_analog_powerdown;
        end
    end
endmodule : rpt_regs

/* File: rpt_regs_asserts.sv */
`timescale 1ns/1ns
module rpt_regs_asserts (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic rx_enable_req,
    input wire logic regulator_powerdown_ctl,
    input wire logic delayed_analog_powerdown,
    input wire logic rx_chain_en,
    input wire logic demod_en,
    input wire logic tx_en,
    input wire logic pa_on,
    input wire logic vga_reset_n,
    input wire logic output_switch_bias_ctl,
    input wire logic prescaler_off,
    input wire logic amp_neg_path_off,
    input wire logic amp_pos_path_off,
    input wire logic tx_converter_off,
    input wire logic up_mixer_off
);
    logic [11:0] req_cnt;

    // Saturating count of cycles the receive request has been held
    always_ff @(posedge mclk)
    begin
        if (!rst_b || !rx_enable_req)
            req_cnt <= 12'h000;
        else if (req_cnt != 12'hFFF)
            req_cnt <= req_cnt + 12'h001;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // Power-down is immediate, power-up only from a powered-up control
    status_off_a: assert property (regulator_powerdown_ctl |=> !delayed_analog_powerdown)
        else $error("status high while regulator off");
    status_wait_a: assert property ($rose(delayed_analog_powerdown) |-> $past(regulator_powerdown_ctl) == 1'b0)
        else $error("status rose without regulator on");
    analog_off_a: assert property (!delayed_analog_powerdown && $past(delayed_analog_powerdown) == 1'b0
        |-> prescaler_off && amp_neg_path_off && amp_pos_path_off && tx_converter_off && !rx_chain_en && !tx_en && !pa_on)
        else $error("analog active while status low");
    mixer_off_a: assert property (amp_neg_path_off && amp_pos_path_off |-> up_mixer_off)
        else $error("mixers on with both paths off");
    rx_cal_a: assert property ($rose(rx_chain_en) |-> req_cnt >= 12'hA28)
        else $error("chain before calibration");
    demod_seq_a: assert property ($rose(demod_en) |-> rx_chain_en)
        else $error("demodulator before chain");
    vga_phase_a: assert property (vga_reset_n |-> demod_en || $past(demod_en))
        else $error("peak reset off outside receive");
    tx_lead_a: assert property ($rose(tx_en) |-> pa_on && output_switch_bias_ctl)
        else $error("transmit without amp and switch");
    tail_order_a: assert property ($fell(pa_on) |-> !tx_en)
        else $error("amp off during transmit");
endmodule : rpt_regs_asserts

bind rpt_regs rpt_regs_asserts i_chk (
    .mclk, .rst_b, .rx_enable_req, .regulator_powerdown_ctl, .delayed_analog_powerdown, .rx_chain_en, .demod_en,
    .tx_en, .pa_on, .vga_reset_n, .output_switch_bias_ctl, .prescaler_off, .amp_neg_path_off, .amp_pos_path_off,
    .tx_converter_off, .up_mixer_off
);

/* File: rpt_radio_model.sv */
`timescale 1ns/1ns
module rpt_radio_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic tx_en,
    input wire logic [7:0] chip_cyc,
    output logic tx_last_chip
);
    logic [7:0] cnt;

    // Frame of chip_cyc chips; last chip flagged for one cycle only
    always_ff @(posedge mclk)
    begin
        if (!rst_b || !tx_en)
        begin
            cnt <= 8'h00;
            tx_last_chip <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 8'h01;
            tx_last_chip <= (cnt == chip_cyc);
        end
    end
endmodule : rpt_radio_model

/* File: radio_power_timing_regs_test.sv */
`timescale 1ns/1ns
`include "rpt_params.svh"
module radio_power_timing_regs_test;
    localparam int unsigned DLY [8] = '{0, 10, 20, 30, 40, 50, 60, 70};
    localparam logic [17:0] REGS [8] = '{`RPT_IDX_X, `RPT_IDX_Y, `RPT_IDX_Z, `RPT_IDX_CTRL, `RPT_IDX_PWR,
        `RPT_IDX_TCH, `RPT_IDX_TCL, `RPT_IDX_MASK};
    localparam logic [7:0] RSTV [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h7A, 8'h94, 8'hFF};
    logic mclk = 1'b0, rst_b = 1'b0, st = 1'b0;
    logic [19:0] s_axi_awaddr = 20'h00000, s_axi_araddr = 20'h00000;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic rx_enable_req = 1'b0, tx_start = 1'b0, tx_last_chip;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] seq_operand_x, seq_operand_y, seq_operand_z;
    logic seq_cpu_ctrl, regulator_powerdown_ctl, delayed_analog_powerdown, rx_chain_en, demod_en, tx_en, mod_en;
    logic pa_on, vga_reset_n, global_bias_off, output_switch_bias_ctl, buffer_select, prescaler_off;
    logic amp_neg_path_off, amp_pos_path_off, tx_converter_off, up_mixer_off;
    logic [5:0] obs;
    int n_errors = 0, n_tests = 0;
    int mdl [int];

    rpt_regs #(.DLY_CYC(DLY)) i_dut (
        .mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_enable_req, .tx_start, .tx_last_chip,
        .seq_operand_x, .seq_operand_y, .seq_operand_z, .seq_cpu_ctrl, .regulator_powerdown_ctl,
        .delayed_analog_powerdown, .rx_chain_en, .demod_en, .tx_en, .mod_en, .pa_on, .vga_reset_n, .global_bias_off,
        .output_switch_bias_ctl, .buffer_select, .prescaler_off, .amp_neg_path_off, .amp_pos_path_off,
        .tx_converter_off, .up_mixer_off
    );
    rpt_radio_model i_far (.mclk, .rst_b, .tx_en, .chip_cyc(8'h20), .tx_last_chip);

    // Watched levels for the bounded waits
    assign obs = {delayed_analog_powerdown, rx_chain_en, demod_en, pa_on, output_switch_bias_ctl, tx_en};

    initial
    begin
        forever #20 mclk = ~mclk;
    end

    task automatic stop_test;
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_cnt(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi)
        begin
            n_errors++;
            $display("mismatch %0t count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_cnt

    task automatic tmo(input int n);
        if (n >= 4000)
        begin
            n_errors++;
            $display("mismatch %0t wait timed out", $time);
            stop_test();
        end
    endtask : tmo

    // Cycles until a watched level is reached, bounded
    task automatic wt(input int b, input logic v, output int n);
        n = 0;
        do
        begin
            @(negedge mclk);
            n++;
        end
        while (obs[b] !== v && n < 4000);
        tmo(n);
    endtask : wt

    // Ready seen mid-cycle; valid drops right after the taking edge
    task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic s, output logic [1:0] r);
        int n = 0;
        logic ad = 1'b0;
        logic wd = 1'b0;
        @(posedge mclk);
        s_axi_awaddr <= {a, 2'b00};
        s_axi_wdata <= {24'($urandom), d};
        s_axi_wstrb <= {3'($urandom), s};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge mclk);
            ad |= s_axi_awvalid && s_axi_awready;
            wd |= s_axi_wvalid && s_axi_wready;
            n++;
            @(posedge mclk);
            if (ad)
                s_axi_awvalid <= 1'b0;
            if (wd)
                s_axi_wvalid <= 1'b0;
        end
        while (!(ad && wd) && n < 4000);
        while (s_axi_bvalid !== 1'b1 && n < 4000)
        begin
            @(negedge mclk);
            n++;
        end
        tmo(n);
        r = s_axi_bresp;
        @(posedge mclk);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        logic ad = 1'b0;
        @(posedge mclk);
        s_axi_araddr <= {a, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge mclk);
            ad |= s_axi_arvalid && s_axi_arready;
            n++;
            @(posedge mclk);
            if (ad)
                s_axi_arvalid <= 1'b0;
        end
        while (!ad && n < 4000);
        while (s_axi_rvalid !== 1'b1 && n < 4000)
        begin
            @(negedge mclk);
            n++;
        end
        tmo(n);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge mclk);
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic mwr(input logic [17:0] a, input logic [7:0] d, input logic s);
        logic [1:0] r;
        wr(a, d, s, r);
        if (s && mdl.exists(a))
            mdl[a] = d;
        chk_val(r, mdl.exists(a) ? 2'b00 : 2'b10);
    endtask : mwr

    // Read-back view: reserved bits zero, status from bench state
    task automatic mrd(input logic [17:0] a);
        logic [31:0] d;
        logic [1:0] r;
        int e;
        rd(a, d, r);
        e = mdl.exists(a) ? mdl[a] : 0;
        case (a)
            `RPT_IDX_CTRL: e = e & 1;
            `RPT_IDX_PWR: e = (e & 15) | (st << 4);
            `RPT_IDX_MASK: e = e & 8'hBF;
            default: ;
        endcase
        chk_val(d, e);
        chk_val(r, mdl.exists(a) ? 2'b00 : 2'b10);
    endtask : mrd

    initial
    begin
        int n;
        logic [7:0] m;
        void'($urandom(32'h3BFABFB2));
        for (int i = 0; i < 8; i++)
            mdl[REGS[i]] = RSTV[i];
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        // Reset state of outputs and registers, then an unmapped word
        @(negedge mclk);
        chk_val({regulator_powerdown_ctl, delayed_analog_powerdown, vga_reset_n, prescaler_off}, 4'h9);
        for (int i = 0; i < 8; i++)
            mrd(REGS[i]);
        mrd(18'h0DF16);
        mwr(18'h0DF16, 8'hA5, 1'b1);
        // Every delay code; power-down must not wait
        for (int k = 0; k < 8; k++)
        begin
            mwr(`RPT_IDX_PWR, 8'(k), 1'b1);
            wt(5, 1'b1, n);
            chk_cnt(n, int'(DLY[k]) - 2, int'(DLY[k]) + 4);
            st = 1'b1;
            mrd(`RPT_IDX_PWR);
            mwr(`RPT_IDX_PWR, 8'(k) | 8'h08, 1'b1);
            st = 1'b0;
            repeat (2) @(negedge mclk);
            chk_val({delayed_analog_powerdown, prescaler_off, tx_converter_off}, 3'h3);
        end
        mwr(`RPT_IDX_PWR, 8'h00, 1'b1);
        wt(5, 1'b1, n);
        st = 1'b1;
        // Random traffic, strobe included; mask gating seen while idle
        repeat (8)
        begin
            for (int i = 0; i < 8; i++)
                if (i != 4)
                    mwr(REGS[i], 8'($urandom), 1'($urandom));
            for (int i = 0; i < 8; i++)
                mrd(REGS[i]);
            m = 8'(mdl[`RPT_IDX_MASK]);
            chk_val({seq_operand_x, seq_operand_y, seq_operand_z, seq_cpu_ctrl}, {8'(mdl[`RPT_IDX_X]),
                8'(mdl[`RPT_IDX_Y]), 8'(mdl[`RPT_IDX_Z]), 1'(mdl[`RPT_IDX_CTRL])});
            chk_val({vga_reset_n, global_bias_off, output_switch_bias_ctl, buffer_select, prescaler_off,
                amp_neg_path_off, amp_pos_path_off, tx_converter_off, up_mixer_off},
                {1'b0, m[6], 2'b00, m[3:0], m[2] & m[1]});
        end
        // Receive: chain 1 step; amplifier lead 5, switch 3, tails 2 and 4
        mwr(`RPT_IDX_MASK, 8'hFF, 1'b1);
        mwr(`RPT_IDX_TCH, 8'h2D, 1'b1);
        mwr(`RPT_IDX_TCL, 8'h54, 1'b1);
        @(posedge mclk);
        rx_enable_req <= 1'b1;
        wt(4, 1'b1, n);
        chk_cnt(n, 2600, 2604);
        wt(3, 1'b1, n);
        chk_cnt(n, 124, 127);
        chk_val(vga_reset_n, 1'b1);
        mwr(`RPT_IDX_MASK, 8'h7F, 1'b1);
        @(negedge mclk);
        chk_val(vga_reset_n, 1'b0);
        @(posedge mclk);
        rx_enable_req <= 1'b0;
        mwr(`RPT_IDX_MASK, 8'hFF, 1'b1);
        // Transmit one frame from the far-side model
        @(posedge mclk);
        tx_start <= 1'b1;
        @(posedge mclk);
        tx_start <= 1'b0;
        wt(2, 1'b1, n);
        wt(1, 1'b1, n);
        chk_cnt(n, 49, 51);
        wt(0, 1'b1, n);
        chk_cnt(n, 74, 76);
        chk_val({buffer_select, amp_neg_path_off, amp_pos_path_off, tx_converter_off, up_mixer_off, mod_en},
            6'h21);
        wt(0, 1'b0, n);
        wt(1, 1'b0, n);
        chk_cnt(n, 47, 52);
        wt(2, 1'b0, n);
        chk_cnt(n, 47, 52);
        chk_val(mod_en, 1'b0);
        stop_test();
    end
endmodule : radio_power_timing_regs_test
